// File: dl_bit_pacer.sv
// Serial bit clock generator with edge strobes.
// Assumes run_i comes from logic on the same clock.
`timescale 1ns/1ps
module dl_bit_pacer #(
    parameter int HALF = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic run_i,
    // Bit clock and strobes
    output logic bit_clk_o,
    output logic rise_o,
    output logic fall_o
);
    logic [3:0] cnt_reg;
    logic wrap;

    assign wrap = (cnt_reg == 4'(HALF - 1));
    assign rise_o = run_i && wrap && !bit_clk_o;
    assign fall_o = run_i && wrap && bit_clk_o;

    // Clock parks low while idle so every frame begins with a rising edge
    always_ff @(posedge clk_i) begin
        if (reset_i || !run_i) begin
            cnt_reg <= 4'h0;
            bit_clk_o <= 1'b0;
        end else if (wrap) begin
            cnt_reg <= 4'h0;
            bit_clk_o <= !bit_clk_o;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // dl_bit_pacer

// File: dl_defines.svh
// Constants for the overhead data link access block.
// Assumes a 100 MHz core clock and an 8-bit register port.
`ifndef DL_DEFINES_SVH
`define DL_DEFINES_SVH

// Register offsets
`define DL_GEN_CTRL_ADDR 8'h00
`define DL_GPO_ADDR 8'h02
`define DL_TX_SEC_CTRL_ADDR 8'h0C
`define DL_TX_LIN_CTRL_ADDR 8'h0D
`define DL_RX_LIN_CTRL_ADDR 8'h46
`define DL_STATUS_ADDR 8'h47

// Field positions
`define DL_SEL_BIT 2
`define DL_TX_SEC_EN_BIT 6
`define DL_TX_LIN_EN_BIT 4
`define DL_RX_LIN_EN_BIT 0
`define DL_RX_SEC_EN_BIT 1

// Reset values
`define DL_REG_RESET 8'h00

// Frame layout: 3 section octets then 9 line octets, 96 bits in all
`define DL_SEC_BITS 7'h18
`define DL_LAST_BIT 7'h5F
`define DL_SEC_OCTETS 4'h3
`define DL_OCTETS 12

// Serial bit timing
`define DL_CLK_NS 10
`define DL_BIT_HALF_NS 60
`define DL_HALF_CYC ((`DL_BIT_HALF_NS + `DL_CLK_NS - 1) / `DL_CLK_NS)

`endif

// File: dl_link_partner.sv
// Behavioural serial source standing on the far side of the transmit data link.
// Assumes the pacing clock and indicator pins are sampled on the core clock.
`timescale 1ns/1ps
module dl_link_partner (
    // Clock and restart
    input wire logic clk_i,
    input wire logic restart_i,
    // Pins from the device
    input wire logic tx_clk_i,
    input wire logic tx_ind_i,
    // Frame to send, bit 95 first
    input wire logic [95:0] frame_bits_i,
    // Serial data to the device
    output logic serial_o = 1'b0
);
    logic clk_q = 1'b0;
    int idx = 0;

    // Data changes after the falling edge so it is steady at the next rise
    always @(posedge clk_i) begin
        clk_q <= tx_clk_i;
        if (restart_i) begin
            idx <= 0;
            serial_o <= frame_bits_i[95];
        end else if (clk_q && !tx_clk_i && idx < 96) begin
            idx <= idx + 1;
            if (idx == 95) begin
                // Released line: show the inverse rather than a stale bit
                serial_o <= ~serial_o;
            end else begin
                // Wrong-channel data when the indicator disagrees, so octet checks see it
                serial_o <= frame_bits_i[94 - idx] ^ (tx_ind_i != (idx < 23));
            end
        end
    end
endmodule // dl_link_partner

// File: dl_pkg.sv
// Types shared by the overhead data link access block.
// Assumes nothing beyond a SystemVerilog compiler.
package dl_pkg;
    typedef logic [7:0] octet_t;
    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_RUN = 1'b1
    } seq_state_t;
endpackage

// File: sonet_data_link_access.sv
// Serial access to section and line data communication octets.
// Assumes framer and register port share clk_i; serial input is asynchronous.
// Contract
// - Four separate data link enables in software
// - Enables override pin-mode only on pins 7-2
// - Unclaimed pins 7-2 follow pin-mode selection
// - Pins 1 and 0 follow pin-mode only
// - Pin-mode shows general output register bits when the select bit is set, live alarms when clear
// - Section enable inserts serial input into D1-D3
// - Line enable inserts serial input into D4-D12
// - Disabled transmit channel octets are all zero
// - Transmit enable claims pins 2, 3, 4
// - Pin 2 pulses at each cell slot
// - Pin 3 high for section, low line
// - Pin 4 drives transmit serial bit clock
// - Receive enables bits 0,1 claim pins 5-7
// - Pin 5 high for section, low line
// - Pin 6 carries received octet bits serially
// - Pin 7 drives receive serial bit clock
`timescale 1ns/1ps
`include "dl_defines.svh"
module sonet_data_link_access (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Live alarms from the framer
    input wire logic los_i,
    input wire logic oof_i,
    input wire logic lop_i,
    input wire logic ais_line_i,
    input wire logic rdi_line_i,
    input wire logic ais_path_i,
    input wire logic [1:0] aux_alarm_i,
    // Transmit framer side
    input wire logic tx_frame_start_i,
    input wire logic tx_cell_slot_i,
    input wire logic [3:0] tx_oct_sel_i,
    output logic [7:0] tx_oct_o,
    // Receive framer side
    input wire logic rx_oct_we_i,
    input wire logic [3:0] rx_oct_idx_i,
    input wire logic [7:0] rx_oct_i,
    input wire logic rx_frame_end_i,
    // Pins
    input wire logic overhead_serial_in_i,
    output logic [7:0] status_pin_o
);
    logic [7:0] gen_ctrl_reg;
    logic [7:0] general_output_register;
    logic [7:0] tx_sec_ctrl_reg;
    logic [7:0] tx_lin_ctrl_reg;
    logic [7:0] rx_lin_ctrl_reg;
    logic status_pin_select_bit;
    logic tx_section_channel_enable;
    logic tx_line_channel_enable;
    logic rx_section_channel_enable;
    logic rx_line_channel_enable;
    logic tx_any;
    logic rx_any;

    dl_pkg::seq_state_t tx_state_reg;
    dl_pkg::seq_state_t rx_state_reg;
    logic [6:0] tx_cnt_reg;
    logic [6:0] rx_cnt_reg;
    logic [6:0] tx_shift_reg;
    dl_pkg::octet_t tx_store_reg [0:`DL_OCTETS-1];
    dl_pkg::octet_t rx_store_reg [0:`DL_OCTETS-1];
    logic ser_meta_reg;
    logic ser_sync_reg;
    logic tx_bit_clk;
    logic tx_rise;
    logic tx_fall;
    logic rx_bit_clk;
    logic rx_fall;
    logic tx_channel_indicator;
    logic rx_channel_indicator;
    logic rx_bit;
    logic [6:0] rx_last;
    logic [7:0] status_pin_next;
    logic [7:0] status_reg;

    assign status_pin_select_bit = gen_ctrl_reg[`DL_SEL_BIT];
    assign tx_section_channel_enable = tx_sec_ctrl_reg[`DL_TX_SEC_EN_BIT];
    assign tx_line_channel_enable = tx_lin_ctrl_reg[`DL_TX_LIN_EN_BIT];
    assign rx_section_channel_enable = rx_lin_ctrl_reg[`DL_RX_SEC_EN_BIT];
    assign rx_line_channel_enable = rx_lin_ctrl_reg[`DL_RX_LIN_EN_BIT];
    assign tx_any = tx_section_channel_enable || tx_line_channel_enable;
    assign rx_any = rx_section_channel_enable || rx_line_channel_enable;

    // Register writes; full bytes are kept so read-back matches
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gen_ctrl_reg <= `DL_REG_RESET;
            general_output_register <= `DL_REG_RESET;
            tx_sec_ctrl_reg <= `DL_REG_RESET;
            tx_lin_ctrl_reg <= `DL_REG_RESET;
            rx_lin_ctrl_reg <= `DL_REG_RESET;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `DL_GEN_CTRL_ADDR: gen_ctrl_reg <= reg_wdata_i;
                `DL_GPO_ADDR: general_output_register <= reg_wdata_i;
                `DL_TX_SEC_CTRL_ADDR: tx_sec_ctrl_reg <= reg_wdata_i;
                `DL_TX_LIN_CTRL_ADDR: tx_lin_ctrl_reg <= reg_wdata_i;
                `DL_RX_LIN_CTRL_ADDR: rx_lin_ctrl_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    assign status_reg = {4'h0, tx_state_reg == dl_pkg::SEQ_RUN, rx_state_reg == dl_pkg::SEQ_RUN,
                         tx_channel_indicator, rx_channel_indicator};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `DL_GEN_CTRL_ADDR: reg_rdata_o <= gen_ctrl_reg;
                `DL_GPO_ADDR: reg_rdata_o <= general_output_register;
                `DL_TX_SEC_CTRL_ADDR: reg_rdata_o <= tx_sec_ctrl_reg;
                `DL_TX_LIN_CTRL_ADDR: reg_rdata_o <= tx_lin_ctrl_reg;
                `DL_RX_LIN_CTRL_ADDR: reg_rdata_o <= rx_lin_ctrl_reg;
                `DL_STATUS_ADDR: reg_rdata_o <= status_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Serial input comes from off chip
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ser_meta_reg <= 1'b0;
            ser_sync_reg <= 1'b0;
        end else begin
            ser_meta_reg <= overhead_serial_in_i;
            ser_sync_reg <= ser_meta_reg;
        end
    end

    dl_bit_pacer #(
        .HALF(`DL_HALF_CYC)
    ) u_tx_pacer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(tx_state_reg == dl_pkg::SEQ_RUN),
        .bit_clk_o(tx_bit_clk),
        .rise_o(tx_rise),
        .fall_o(tx_fall)
    );

    dl_bit_pacer #(
        .HALF(`DL_HALF_CYC)
    ) u_rx_pacer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(rx_state_reg == dl_pkg::SEQ_RUN),
        .bit_clk_o(rx_bit_clk),
        .rise_o(),
        .fall_o(rx_fall)
    );

    // Transmit bit sequencer: 96 bits per frame, advanced on falling edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_state_reg <= dl_pkg::SEQ_IDLE;
            tx_cnt_reg <= 7'h00;
        end else begin
            unique case (tx_state_reg)
                dl_pkg::SEQ_IDLE: begin
                    if (tx_frame_start_i && tx_any) begin
                        tx_state_reg <= dl_pkg::SEQ_RUN;
                        tx_cnt_reg <= 7'h00;
                    end
                end
                dl_pkg::SEQ_RUN: begin
                    if (!tx_any) begin
                        tx_state_reg <= dl_pkg::SEQ_IDLE;
                    end else if (tx_fall) begin
                        if (tx_cnt_reg == `DL_LAST_BIT) begin
                            tx_state_reg <= dl_pkg::SEQ_IDLE;
                        end else begin
                            tx_cnt_reg <= tx_cnt_reg + 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    // The source launches on the falling edge, so the bit is taken at the rise
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_shift_reg <= 7'h00;
            for (int i = 0; i < `DL_OCTETS; i++) begin
                tx_store_reg[i] <= 8'h00;
            end
        end else if (tx_state_reg == dl_pkg::SEQ_RUN && tx_rise) begin
            tx_shift_reg <= {tx_shift_reg[5:0], ser_sync_reg};
            if (tx_cnt_reg[2:0] == 3'h7) begin
                tx_store_reg[tx_cnt_reg[6:3]] <= {tx_shift_reg, ser_sync_reg};
            end
        end
    end

    // Octets handed to the framer; a disabled channel reads as zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_oct_o <= 8'h00;
        end else if (tx_oct_sel_i < `DL_SEC_OCTETS) begin
            tx_oct_o <= tx_section_channel_enable ? tx_store_reg[tx_oct_sel_i] : 8'h00;
        end else if (tx_oct_sel_i < 4'(`DL_OCTETS)) begin
            tx_oct_o <= tx_line_channel_enable ? tx_store_reg[tx_oct_sel_i] : 8'h00;
        end else begin
            tx_oct_o <= 8'h00;
        end
    end

    // Idle reads high: the next bits asked for are section bits
    assign tx_channel_indicator = (tx_state_reg == dl_pkg::SEQ_IDLE)
                                  || (tx_cnt_reg < `DL_SEC_BITS);

    // Receive store is written by the framer as octets arrive
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < `DL_OCTETS; i++) begin
                rx_store_reg[i] <= 8'h00;
            end
        end else if (rx_oct_we_i && rx_oct_idx_i < 4'(`DL_OCTETS)) begin
            rx_store_reg[rx_oct_idx_i] <= rx_oct_i;
        end
    end

    // Only enabled channels are shifted out, section first
    assign rx_last = rx_line_channel_enable ? `DL_LAST_BIT : (`DL_SEC_BITS - 7'h01);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_state_reg <= dl_pkg::SEQ_IDLE;
            rx_cnt_reg <= 7'h00;
        end else begin
            unique case (rx_state_reg)
                dl_pkg::SEQ_IDLE: begin
                    if (rx_frame_end_i && rx_any) begin
                        rx_state_reg <= dl_pkg::SEQ_RUN;
                        rx_cnt_reg <= rx_section_channel_enable ? 7'h00 : `DL_SEC_BITS;
                    end
                end
                dl_pkg::SEQ_RUN: begin
                    if (!rx_any) begin
                        rx_state_reg <= dl_pkg::SEQ_IDLE;
                    end else if (rx_fall) begin
                        if (rx_cnt_reg >= rx_last) begin
                            rx_state_reg <= dl_pkg::SEQ_IDLE;
                        end else begin
                            rx_cnt_reg <= rx_cnt_reg + 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Bits leave most significant first and change after each falling edge
    assign rx_bit = (rx_state_reg == dl_pkg::SEQ_RUN)
                    && rx_store_reg[rx_cnt_reg[6:3]][3'h7 - rx_cnt_reg[2:0]];
    assign rx_channel_indicator = (rx_state_reg == dl_pkg::SEQ_RUN)
                                  ? (rx_cnt_reg < `DL_SEC_BITS)
                                  : rx_section_channel_enable;

    // Pin selection: data link claims first, then pin-mode
    always_comb begin
        status_pin_next = status_pin_select_bit ? general_output_register
                          : {los_i, oof_i, lop_i, ais_line_i, rdi_line_i, ais_path_i,
                             aux_alarm_i};
        if (tx_any) begin
            status_pin_next[4] = tx_bit_clk;
            status_pin_next[3] = tx_channel_indicator;
            status_pin_next[2] = tx_cell_slot_i;
        end
        if (rx_any) begin
            status_pin_next[7] = rx_bit_clk;
            status_pin_next[6] = rx_bit;
            status_pin_next[5] = rx_channel_indicator;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_pin_o <= 8'h00;
        end else begin
            status_pin_o <= status_pin_next;
        end
    end

    sequence s_tx_start;
        tx_frame_start_i && tx_any && tx_state_reg == dl_pkg::SEQ_IDLE;
    endsequence

    sequence s_tx_first_bits;
        (tx_state_reg == dl_pkg::SEQ_RUN && tx_channel_indicator) [*8];
    endsequence

    property p_tx_frame_start;
        @(posedge clk_i) disable iff (reset_i)
        s_tx_start |=> (!status_pin_o[4]) [*7] ##1 status_pin_o[4];
    endproperty
    a_tx_frame_start: assert property (p_tx_frame_start)
        else $error("transmit bit clock misplaced");

    property p_tx_run;
        @(posedge clk_i) disable iff (reset_i)
        s_tx_start |=> s_tx_first_bits;
    endproperty
    a_tx_run: assert property (p_tx_run) else $error("transmit sequence did not start");

    property p_low_pins;
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> status_pin_o[1:0] == ($past(status_pin_select_bit)
            ? $past(general_output_register[1:0]) : $past(aux_alarm_i));
    endproperty
    a_low_pins: assert property (p_low_pins) else $error("pins 1-0 wrong source");

    property p_alarms;
        @(posedge clk_i) disable iff (reset_i)
        !status_pin_select_bit && !tx_any && !rx_any
        |=> status_pin_o[7:2] == $past({los_i, oof_i, lop_i, ais_line_i, rdi_line_i, ais_path_i});
    endproperty
    a_alarms: assert property (p_alarms) else $error("alarm pins wrong");

    property p_gpo;
        @(posedge clk_i) disable iff (reset_i)
        status_pin_select_bit && !tx_any |=> status_pin_o[4:2] == $past(general_output_register[4:2]);
    endproperty
    a_gpo: assert property (p_gpo) else $error("general output not on free pins");

    property p_tx_clk_pin;
        @(posedge clk_i) disable iff (reset_i)
        tx_any |=> status_pin_o[4] == $past(tx_bit_clk) && status_pin_o[3] == $past(tx_channel_indicator);
    endproperty
    a_tx_clk_pin: assert property (p_tx_clk_pin) else $error("transmit pins not claimed");

    property p_slot;
        @(posedge clk_i) disable iff (reset_i)
        tx_any && tx_cell_slot_i |=> status_pin_o[2];
    endproperty
    a_slot: assert property (p_slot) else $error("cell slot pulse missing");

    property p_tx_zero;
        @(posedge clk_i) disable iff (reset_i)
        !tx_section_channel_enable && tx_oct_sel_i < `DL_SEC_OCTETS |=> tx_oct_o == 8'h00;
    endproperty
    a_tx_zero: assert property (p_tx_zero) else $error("disabled section octet not zero");

    property p_rx_pins;
        @(posedge clk_i) disable iff (reset_i)
        rx_any |=> status_pin_o[7] == $past(rx_bit_clk) && status_pin_o[6] == $past(rx_bit);
    endproperty
    a_rx_pins: assert property (p_rx_pins) else $error("receive pins not claimed");

    property p_rx_ind;
        @(posedge clk_i) disable iff (reset_i)
        rx_state_reg == dl_pkg::SEQ_RUN && rx_any && rx_cnt_reg >= `DL_SEC_BITS
        |=> !status_pin_o[5];
    endproperty
    a_rx_ind: assert property (p_rx_ind) else $error("receive indicator high on line bits");

    property p_rx_clk_quiet;
        @(posedge clk_i) disable iff (reset_i)
        rx_state_reg == dl_pkg::SEQ_IDLE && rx_any |=> !status_pin_o[7];
    endproperty
    a_rx_clk_quiet: assert property (p_rx_clk_quiet) else $error("receive clock runs idle");
endmodule // sonet_data_link_access

// File: test_sonet_data_link_access.sv
// Self-checking bench for the overhead data link access block.
// Assumes dl_link_partner as the serial source on the transmit link.
`timescale 1ns/1ps
module test_sonet_data_link_access;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] alarms = 8'h00;
    logic tx_frame_start_i = 1'b0;
    logic tx_cell_slot_i = 1'b0;
    logic [3:0] tx_oct_sel_i = 4'h0;
    logic [7:0] tx_oct_o;
    logic rx_oct_we_i = 1'b0;
    logic [3:0] rx_oct_idx_i = 4'h0;
    logic [7:0] rx_oct_i = 8'h00;
    logic rx_frame_end_i = 1'b0;
    logic overhead_serial_in_i;
    logic [7:0] status_pin_o;
    logic [95:0] frame_bits = 96'h0;
    logic restart = 1'b0;
    logic [31:0] lfsr = 32'h96DF33C4;
    logic tx_watch = 1'b0;
    logic rx_watch = 1'b0;
    logic p4_q = 1'b0;
    logic p7_q = 1'b0;
    logic [1:0] e2;
    logic [7:0] mreg[256];
    logic [7:0] rx_mem[12];
    logic [1:0] rx_exp[$];
    logic [7:0] addrs[5] = '{8'h00, 8'h02, 8'h0C, 8'h0D, 8'h46};
    int fail_count = 0;
    int checks_done = 0;
    int tx_rises = 0;
    int rx_rises = 0;

    sonet_data_link_access u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .los_i(alarms[7]), .oof_i(alarms[6]), .lop_i(alarms[5]), .ais_line_i(alarms[4]),
        .rdi_line_i(alarms[3]), .ais_path_i(alarms[2]), .aux_alarm_i(alarms[1:0]),
        .tx_frame_start_i(tx_frame_start_i), .tx_cell_slot_i(tx_cell_slot_i),
        .tx_oct_sel_i(tx_oct_sel_i), .tx_oct_o(tx_oct_o), .rx_oct_we_i(rx_oct_we_i),
        .rx_oct_idx_i(rx_oct_idx_i), .rx_oct_i(rx_oct_i), .rx_frame_end_i(rx_frame_end_i),
        .overhead_serial_in_i(overhead_serial_in_i), .status_pin_o(status_pin_o));

    dl_link_partner u_partner (
        .clk_i(clk_i), .restart_i(restart), .tx_clk_i(status_pin_o[4]),
        .tx_ind_i(status_pin_o[3]), .frame_bits_i(frame_bits),
        .serial_o(overhead_serial_in_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        if (a inside {8'h00, 8'h02, 8'h0C, 8'h0D, 8'h46})
            mreg[a] = d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        #1 d = reg_rdata_o;
    endtask

    task automatic wait_rises(ref int cnt, input int n);
        for (int i = 0; i < 3000 && cnt < n; i++)
            @(posedge clk_i);
        repeat (40) @(posedge clk_i);
    endtask

    // Pins as the rules place them while no frame is running
    function automatic logic [7:0] exp_pins();
        logic [7:0] e;
        e = mreg[8'h00][2] ? mreg[8'h02] : alarms;
        if (mreg[8'h0C][6] | mreg[8'h0D][4])
            e[4:2] = 3'b010;
        if (mreg[8'h46][0] | mreg[8'h46][1])
            e[7:5] = {2'b00, mreg[8'h46][1]};
        return e;
    endfunction

    // Serial monitors: sample indicator, and on receive also data, at each bit clock rise
    always @(posedge clk_i) begin
        p4_q <= status_pin_o[4];
        p7_q <= status_pin_o[7];
        if (tx_watch && status_pin_o[4] && !p4_q) begin
            chk_bit("tx indicator", tx_rises < 24, status_pin_o[3]);
            tx_rises++;
        end
        if (rx_watch && status_pin_o[7] && !p7_q) begin
            rx_rises++;
            e2 = (rx_exp.size() > 0) ? rx_exp.pop_front() : 2'bxx;
            chk_bit("rx indicator", e2[1], status_pin_o[5]);
            chk_bit("rx data", e2[0], status_pin_o[6]);
        end
    end

    task automatic tx_frame(input logic [7:0] sec_v, input logic [7:0] lin_v);
        logic [7:0] e;
        reg_write(8'h0C, sec_v);
        reg_write(8'h0D, lin_v);
        for (int k = 0; k < 12; k++)
            frame_bits = {frame_bits[87:0], rnd()};
        @(posedge clk_i);
        restart <= 1'b1;
        @(posedge clk_i);
        restart <= 1'b0;
        tx_rises = 0;
        tx_watch = 1'b1;
        tx_frame_start_i <= 1'b1;
        @(posedge clk_i);
        tx_frame_start_i <= 1'b0;
        wait_rises(tx_rises, 96);
        tx_watch = 1'b0;
        chk_byte("tx clock count", 8'h60, tx_rises[7:0]);
        for (int k = 0; k < 12; k++) begin
            e = ((k < 3) ? sec_v[6] : lin_v[4]) ? frame_bits[95 - 8 * k -: 8] : 8'h00;
            @(posedge clk_i);
            tx_oct_sel_i <= k[3:0];
            @(posedge clk_i);
            @(posedge clk_i);
            #1 chk_byte("tx octet", e, tx_oct_o);
        end
    endtask

    task automatic rx_frame(input logic [7:0] en);
        int n;
        reg_write(8'h46, en);
        for (int k = 0; k < 12; k++) begin
            @(posedge clk_i);
            rx_mem[k] = rnd();
            rx_oct_we_i <= 1'b1;
            rx_oct_idx_i <= k[3:0];
            rx_oct_i <= rx_mem[k];
        end
        @(posedge clk_i);
        rx_oct_we_i <= 1'b0;
        for (int b = 0; b < 96; b++)
            if ((b < 24) ? en[1] : en[0])
                rx_exp.push_back({b < 24, rx_mem[b / 8][7 - b % 8]});
        n = rx_exp.size();
        rx_rises = 0;
        rx_watch = 1'b1;
        rx_frame_end_i <= 1'b1;
        @(posedge clk_i);
        rx_frame_end_i <= 1'b0;
        wait_rises(rx_rises, n);
        rx_watch = 1'b0;
        chk_byte("rx clock count", n[7:0], rx_rises[7:0]);
        rx_exp.delete();
    endtask

    initial begin
        logic [7:0] d;
        foreach (mreg[i])
            mreg[i] = 8'h00;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_read(8'h47, d);
        chk_byte("status reg", 8'h02, d);
        foreach (addrs[i]) begin
            reg_read(addrs[i], d);
            chk_byte("reset value", 8'h00, d);
            reg_write(addrs[i], rnd());
            reg_read(addrs[i], d);
            chk_byte("read back", mreg[addrs[i]], d);
        end
        reg_write(8'h33, rnd());
        reg_read(8'h33, d);
        chk_byte("unmapped read", 8'h00, d);
        for (int i = 0; i < 24; i++) begin
            alarms <= rnd();
            foreach (addrs[j])
                reg_write(addrs[j], rnd());
            repeat (3) @(posedge clk_i);
            // on the next line
            #1 chk_byte("status pins", exp_pins(), status_pin_o);
        end
        foreach (addrs[j])
            reg_write(addrs[j], 8'h00);
        reg_write(8'h0C, 8'h40);
        @(posedge clk_i);
        tx_cell_slot_i <= 1'b1;
        @(posedge clk_i);
        tx_cell_slot_i <= 1'b0;
        #1 chk_bit("slot pulse", 1'b1, status_pin_o[2]);
        @(posedge clk_i);
        #1 chk_bit("slot pulse end", 1'b0, status_pin_o[2]);
        tx_frame(8'h40, 8'h00);
        tx_frame(8'h00, 8'h10);
        tx_frame(8'hFF, 8'hFF);
        reg_write(8'h0C, 8'h00);
        reg_write(8'h0D, 8'h00);
        rx_frame(8'h03);
        rx_frame(8'h01);
        rx_frame(8'h02);
        report_and_stop();
    end

    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule // test_sonet_data_link_access
